/* File: inc/acpra_pkg.sv */
package acpra_pkg;

   localparam int unsigned SEL_W   = 3;
   localparam int unsigned CONV_W  = 12;
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned BYTE_W  = 8;

   // Selector codes
   localparam logic [SEL_W-1:0] SEL_RESULT  = 3'h0;
   localparam logic [SEL_W-1:0] SEL_STATUS  = 3'h1;
   localparam logic [SEL_W-1:0] SEL_CONFIG  = 3'h2;
   localparam logic [SEL_W-1:0] SEL_LOW     = 3'h3;
   localparam logic [SEL_W-1:0] SEL_HIGH    = 3'h4;
   localparam logic [SEL_W-1:0] SEL_HYST    = 3'h5;
   localparam logic [SEL_W-1:0] SEL_LOWEST  = 3'h6;
   localparam logic [SEL_W-1:0] SEL_HIGHEST = 3'h7;

   // Field positions
   localparam int unsigned RES_ALERT_BIT   = 15;
   localparam int unsigned STAT_OVER_BIT   = 1;
   localparam int unsigned STAT_UNDER_BIT  = 0;
   localparam int unsigned CFG_CYCLE_HI    = 7;
   localparam int unsigned CFG_CYCLE_LO    = 5;
   localparam int unsigned CFG_HOLD_BIT    = 4;
   localparam int unsigned CFG_FLAG_EN_BIT = 3;

   // Reset values and fill
   localparam logic [SEL_W-1:0]  PTR_RESET    = 3'h0;
   localparam logic [CONV_W-1:0] CONV_RESET   = 12'h000;
   localparam logic              FLAG_RESET   = 1'h0;
   localparam logic [WORD_W-1:0] WORD_RESET   = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RESET   = 8'h00;
   localparam logic [2:0]        RES_RSVD     = 3'h0;
   localparam logic [5:0]        STAT_RSVD    = 6'h00;

   typedef struct packed {
      logic [CONV_W-1:0] low;
      logic [CONV_W-1:0] high;
      logic [CONV_W-1:0] hysteresis_amount;
   } acpra_limits_t;

   typedef struct packed {
      logic [SEL_W-1:0]  sel;
      logic [WORD_W-1:0] data;
   } acpra_ext_wr_t;

   typedef enum logic [1:0] {
      WR_PTR = 2'b00,
      WR_HI  = 2'b01,
      WR_LO  = 2'b10
   } acpra_wr_state_t;

endpackage : acpra_pkg

/* File: rtl/acpra_flag.sv */
`timescale 1ns/1ps
module acpra_flag
   import acpra_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   input  wire logic set_i,
   input  wire logic relax_i,
   input  wire logic hold_i,
   input  wire logic wr_clr_i,
   output logic      flag_o
);

   logic flag;
   logic next_flag;

   // Set wins over any clear in the same cycle
   assign next_flag = set_i | (flag & ~wr_clr_i & ~(relax_i & ~hold_i)); // see R13, R16

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         flag <= FLAG_RESET;
      end else begin
         flag <= next_flag;
      end
   end

   assign flag_o = flag;

   flag_set_a: assert property ( // see R11
      @(posedge ref_clk_i) disable iff (!nrst_i) set_i |=> flag_o)
      else $error("flag not set after event");

   flag_wclr_a: assert property ( // see R13
      @(posedge ref_clk_i) disable iff (!nrst_i) wr_clr_i && !set_i |=> !flag_o)
      else $error("flag not cleared by written one");

   flag_relax_a: assert property ( // see R14
      @(posedge ref_clk_i) disable iff (!nrst_i)
      relax_i && !hold_i && !set_i |=> !flag_o)
      else $error("flag did not self-clear");

   flag_hold_a: assert property ( // see R16
      @(posedge ref_clk_i) disable iff (!nrst_i)
      flag_o && hold_i && !wr_clr_i |=> flag_o)
      else $error("held flag cleared without write");

endmodule : acpra_flag

/* File: rtl/acpra_result.sv */
`timescale 1ns/1ps
module acpra_result
   import acpra_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   input  wire logic              done_i,
   input  wire logic [CONV_W-1:0] data_i,
   output logic      [CONV_W-1:0] result_o
);

   logic [CONV_W-1:0] result;

   // Only a finished conversion loads the value; bus writes never reach it
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         result <= CONV_RESET; // see R08
      end else if (done_i) begin
         result <= data_i; // see R06
      end
   end

   assign result_o = result;

   res_load_a: assert property ( // see R06
      @(posedge ref_clk_i) disable iff (!nrst_i)
      done_i |=> result_o == $past(data_i))
      else $error("result not loaded on completion");

   res_keep_a: assert property ( // see R08
      @(posedge ref_clk_i) disable iff (!nrst_i) !done_i |=> $stable(result_o))
      else $error("result changed without conversion");

endmodule : acpra_result

/* File: rtl/acpra_regs.sv */
// Functional notes
// R01: First byte of each write transaction loads the select pointer.
// R02: Later write bytes and all reads go to the pointer-selected register.
// R03: Only pointer bits 2..0 select; controller writes zeros above them.
// R04: Pointer clears to zero at reset, selecting the conversion result.
// R05: Selector decode 0..7; all but the result are readable and writable.
// R06: Result read in normal mode starts a conversion; holds latest result.
// R07: Result in bits 11..0, straight binary; bits 14..12 read zero.
// R08: Result register ignores writes and resets to zero.
// R09: Bit 15 reads one only if flag enable set and any alert flag set.
// R10: Status resets to zero; bits 7..2 read zero, written as zero.
// R11: Over-range flag bit 1 sets when a result exceeds the upper limit.
// R12: Under-range flag bit 0 sets when a result is below the lower limit.
// R13: Writing one to a flag clears it; writing zero leaves it.
// R14: Without hold, over flag clears below upper limit minus hysteresis.
// R15: Without hold, under flag clears above lower limit plus hysteresis.
// R16: With hold on, flags clear only by a written one.
// R17: Configuration bit 4 selects alert hold.
// R18: Configuration bit 3 enables the summary alert bit 15.
// R19: Pointer keeps its value until the next write transaction replaces it.
`timescale 1ns/1ps
module acpra_regs
   import acpra_pkg::*;
(
   input  wire logic                ref_clk_i,
   input  wire logic                nrst_i,
   input  wire logic                wr_valid_i,
   input  wire logic                wr_first_i,
   input  wire logic [BYTE_W-1:0]   wr_byte_i,
   input  wire logic                rd_req_i,
   output logic      [WORD_W-1:0]   rd_data_o,
   output logic                     rd_wide_o,
   output logic                     rd_valid_o,
   input  wire logic [WORD_W-1:0]   ext_rd_data_i,
   output logic                     ext_wr_o,
   output acpra_ext_wr_t            ext_wr_data_o,
   input  wire logic [BYTE_W-1:0]   cfg_i,
   input  wire acpra_limits_t       limits_i,
   input  wire logic                conv_done_i,
   input  wire logic [CONV_W-1:0]   conv_data_i,
   output logic                     conv_start_o,
   output logic      [SEL_W-1:0]    sel_o,
   output logic      [1:0]          alert_flags_o
);

   logic [SEL_W-1:0]  ptr;
   acpra_wr_state_t   state;
   acpra_wr_state_t   next_state;
   logic [BYTE_W-1:0] hi_byte;
   logic [CONV_W-1:0] result;
   logic              over_flag;
   logic              under_flag;
   logic [WORD_W-1:0] rd_data;
   logic              rd_wide;
   logic              rd_valid;
   logic              ext_wr;
   acpra_ext_wr_t     ext_wr_data;
   logic              conv_start;

   // Configuration decode
   wire cfg_hold    = cfg_i[CFG_HOLD_BIT];    // see R17
   wire cfg_flag_en = cfg_i[CFG_FLAG_EN_BIT]; // see R18
   wire cfg_auto    = |cfg_i[CFG_CYCLE_HI:CFG_CYCLE_LO];

   // Byte classification
   wire ptr_byte  = wr_valid_i & wr_first_i;
   wire data_byte = wr_valid_i & ~wr_first_i & (state != WR_PTR);

   // Status and configuration are one byte wide, the rest two
   wire sel_narrow = (ptr == SEL_STATUS) | (ptr == SEL_CONFIG); // see R05
   wire sel_wide   = ~sel_narrow;

   wire wr_hi_byte = data_byte & (state == WR_HI);
   wire wr_lo_byte = data_byte & (state == WR_LO);

   // Result is read only, status is handled here
   wire ext_narrow = wr_hi_byte & (ptr == SEL_CONFIG);
   wire ext_wide   = wr_lo_byte & (ptr != SEL_RESULT); // see R08
   wire next_ext_wr = ext_narrow | ext_wide; // see R02

   wire [WORD_W-1:0] ext_word = ext_narrow ? {BYTE_RESET, wr_byte_i}
                                           : {hi_byte, wr_byte_i};

   wire status_wr = wr_hi_byte & (ptr == SEL_STATUS);
   wire over_wclr  = status_wr & wr_byte_i[STAT_OVER_BIT];  // see R13
   wire under_wclr = status_wr & wr_byte_i[STAT_UNDER_BIT]; // see R13

   // Limit comparison, widened so the hysteresis sums cannot wrap
   wire [CONV_W:0] data_x = {1'b0, conv_data_i};
   wire [CONV_W:0] high_x = {1'b0, limits_i.high};
   wire [CONV_W:0] low_x  = {1'b0, limits_i.low};
   wire [CONV_W:0] hyst_x = {1'b0, limits_i.hysteresis_amount};
   wire [CONV_W:0] data_plus_hyst = data_x + hyst_x;
   wire [CONV_W:0] low_plus_hyst  = low_x + hyst_x;

   wire over_set    = conv_done_i & (data_x > high_x);          // see R11
   wire under_set   = conv_done_i & (data_x < low_x);           // see R12
   wire over_relax  = conv_done_i & (data_plus_hyst < high_x);  // see R14
   wire under_relax = conv_done_i & (data_x > low_plus_hyst);   // see R15

   // Read selection
   wire alert_sum = cfg_flag_en & (over_flag | under_flag); // see R09
   wire [WORD_W-1:0] result_word = {alert_sum, RES_RSVD, result}; // see R07
   wire [WORD_W-1:0] status_word = {BYTE_RESET, STAT_RSVD, over_flag,
                                    under_flag}; // see R10
   wire [WORD_W-1:0] sel_word = (ptr == SEL_RESULT) ? result_word :
                                (ptr == SEL_STATUS) ? status_word :
                                ext_rd_data_i; // see R02, R05

   // Reading the result in normal mode kicks a fresh conversion
   wire next_conv_start = rd_req_i & (ptr == SEL_RESULT) & ~cfg_auto; // see R06

   always_comb begin
      next_state = state;
      case (state)
         WR_PTR: begin
            if (ptr_byte) begin
               next_state = WR_HI;
            end
         end
         WR_HI: begin
            if (ptr_byte) begin
               next_state = WR_HI;
            end else if (data_byte && sel_wide) begin
               next_state = WR_LO;
            end
         end
         WR_LO: begin
            if (ptr_byte || data_byte) begin
               next_state = WR_HI;
            end
         end
         default: begin
            next_state = WR_PTR;
         end
      endcase
   end

   // Pointer lives across transactions; only a first byte replaces it
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ptr <= PTR_RESET; // see R04
      end else if (ptr_byte) begin
         ptr <= wr_byte_i[SEL_W-1:0]; // see R01, R03, R19
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         state   <= WR_PTR;
         hi_byte <= BYTE_RESET;
      end else begin
         state <= next_state;
         if (wr_hi_byte) begin
            hi_byte <= wr_byte_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ext_wr      <= 1'b0;
         ext_wr_data <= '0;
      end else begin
         ext_wr <= next_ext_wr;
         if (next_ext_wr) begin
            ext_wr_data <= '{sel: ptr, data: ext_word};
         end
      end
   end

   // Read word is captured so a flag change mid-transfer cannot tear it
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_data    <= WORD_RESET;
         rd_wide    <= 1'b0;
         rd_valid   <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         rd_valid   <= rd_req_i;
         conv_start <= next_conv_start;
         if (rd_req_i) begin
            rd_data <= sel_word;
            rd_wide <= sel_wide;
         end
      end
   end

   acpra_result u_result (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .done_i    (conv_done_i),
      .data_i    (conv_data_i),
      .result_o  (result)
   );

   acpra_flag u_over (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (over_set),
      .relax_i   (over_relax),
      .hold_i    (cfg_hold),
      .wr_clr_i  (over_wclr),
      .flag_o    (over_flag)
   );

   acpra_flag u_under (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (under_set),
      .relax_i   (under_relax),
      .hold_i    (cfg_hold),
      .wr_clr_i  (under_wclr),
      .flag_o    (under_flag)
   );

   assign rd_data_o     = rd_data;
   assign rd_wide_o     = rd_wide;
   assign rd_valid_o    = rd_valid;
   assign ext_wr_o      = ext_wr;
   assign ext_wr_data_o = ext_wr_data;
   assign conv_start_o  = conv_start;
   assign sel_o         = ptr;
   assign alert_flags_o = {over_flag, under_flag};

   ptr_load_a: assert property ( // see R01
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ptr_byte |=> sel_o == $past(wr_byte_i[SEL_W-1:0]))
      else $error("pointer not loaded from first byte");

   ptr_keep_a: assert property ( // see R19
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !(wr_valid_i && wr_first_i) |=> $stable(sel_o))
      else $error("pointer changed without first byte");

   ptr_reset_a: assert property ( // see R04
      @(posedge ref_clk_i) $rose(nrst_i) |-> sel_o == SEL_RESULT)
      else $error("pointer not zero after reset");

   ext_pair_a: assert property ( // see R02
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ptr_byte ##1 (wr_valid_i && !wr_first_i && sel_o == SEL_LOW)
      ##1 (wr_valid_i && !wr_first_i)
      |=> ext_wr_o && ext_wr_data_o.sel == SEL_LOW
          && ext_wr_data_o.data == {$past(wr_byte_i, 2), $past(wr_byte_i)})
      else $error("paired write not forwarded");

   res_nowr_a: assert property ( // see R08
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ext_wr_o |-> ext_wr_data_o.sel != SEL_RESULT && ext_wr_data_o.sel != SEL_STATUS)
      else $error("write forwarded to internal register");

   conv_kick_a: assert property ( // see R06
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rd_req_i && sel_o == SEL_RESULT && cfg_i[CFG_CYCLE_HI:CFG_CYCLE_LO] == 3'h0
      |=> conv_start_o ##1 !conv_start_o || $past(rd_req_i))
      else $error("result read did not start conversion");

   res_word_a: assert property ( // see R07
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rd_req_i && sel_o == SEL_RESULT
      |=> rd_valid_o && rd_data_o[14:12] == RES_RSVD && rd_data_o[11:0] == $past(result))
      else $error("result word layout wrong");

   alert_sum_a: assert property ( // see R09
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rd_req_i && sel_o == SEL_RESULT
      |=> rd_data_o[RES_ALERT_BIT] == $past(cfg_i[CFG_FLAG_EN_BIT] && |alert_flags_o))
      else $error("summary alert bit wrong");

   stat_rsvd_a: assert property ( // see R10
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rd_req_i && sel_o == SEL_STATUS |=> rd_data_o[15:2] == 14'h0000 && !rd_wide_o)
      else $error("status reserved bits not zero");

   over_limit_a: assert property ( // see R11
      @(posedge ref_clk_i) disable iff (!nrst_i)
      conv_done_i && conv_data_i > limits_i.high |=> alert_flags_o[STAT_OVER_BIT])
      else $error("over-range flag not set");

   under_limit_a: assert property ( // see R12
      @(posedge ref_clk_i) disable iff (!nrst_i)
      conv_done_i && conv_data_i < limits_i.low |=> alert_flags_o[STAT_UNDER_BIT])
      else $error("under-range flag not set");

   under_relax_a: assert property ( // see R15
      @(posedge ref_clk_i) disable iff (!nrst_i)
      under_relax && !cfg_i[CFG_HOLD_BIT] |=> !alert_flags_o[STAT_UNDER_BIT])
      else $error("under-range flag did not self-clear");

endmodule : acpra_regs

/* File: test/acpra_host_model.sv */
`timescale 1ns/1ps
module acpra_host_model
   import acpra_pkg::*;
(
   input  wire logic              ref_clk_i,
   output logic                   wr_valid_o,
   output logic                   wr_first_o,
   output logic      [BYTE_W-1:0] wr_byte_o,
   output logic                   rd_req_o
);
   initial begin
      wr_valid_o = 1'b0;
      wr_first_o = 1'b0;
      wr_byte_o  = 8'h00;
      rd_req_o   = 1'b0;
   end

   // Gap inserts idle cycles between bytes to act as a slow controller
   task automatic write_reg(input logic [SEL_W-1:0] sel, input logic [WORD_W-1:0] data,
                            input int gap);
      int n;
      n = (sel == SEL_STATUS || sel == SEL_CONFIG) ? 1 : 2;
      if (sel == SEL_STATUS)
         data = data & 16'h0003;
      @(negedge ref_clk_i);
      wr_valid_o = 1'b1;
      wr_first_o = 1'b1;
      wr_byte_o  = {5'h00, sel};
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge ref_clk_i);
         wr_first_o = 1'b0;
         if (gap > 0) begin
            wr_valid_o = 1'b0;
            wr_byte_o  = ~wr_byte_o;
            repeat (gap) @(negedge ref_clk_i);
            wr_valid_o = 1'b1;
         end
         wr_byte_o = data[8*i +: 8];
      end
      @(negedge ref_clk_i);
      wr_valid_o = 1'b0;
      wr_byte_o  = ~wr_byte_o;
   endtask : write_reg

   task automatic read_reg();
      @(negedge ref_clk_i);
      rd_req_o = 1'b1;
      @(negedge ref_clk_i);
      rd_req_o = 1'b0;
   endtask : read_reg
endmodule : acpra_host_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench
   import acpra_pkg::*;
;
   logic              ref_clk_i = 1'b0;
   logic              nrst_i    = 1'b0;
   logic              wr_valid, wr_first, rd_req, rd_wide, rd_valid, ext_wr;
   logic              conv_done, conv_start;
   logic [BYTE_W-1:0] wr_byte, cfg;
   logic [WORD_W-1:0] rd_data, ext_rd;
   logic [CONV_W-1:0] conv_data;
   logic [SEL_W-1:0]  sel;
   logic [1:0]        flags;
   acpra_ext_wr_t     ext_wr_data;
   acpra_limits_t     limits;
   int                err_total = 0;
   int                tests_run = 0;
   int                seed      = 23;
   int                m_over, m_under, m_res, d, h, l, y;
   int                pick[8];

   always #2.5 ref_clk_i = ~ref_clk_i;

   acpra_host_model u_host (.ref_clk_i(ref_clk_i), .wr_valid_o(wr_valid),
      .wr_first_o(wr_first), .wr_byte_o(wr_byte), .rd_req_o(rd_req));

   acpra_regs dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wr_valid_i(wr_valid),
      .wr_first_i(wr_first), .wr_byte_i(wr_byte), .rd_req_i(rd_req), .rd_data_o(rd_data),
      .rd_wide_o(rd_wide), .rd_valid_o(rd_valid), .ext_rd_data_i(ext_rd), .ext_wr_o(ext_wr),
      .ext_wr_data_o(ext_wr_data), .cfg_i(cfg), .limits_i(limits),
      .conv_done_i(conv_done), .conv_data_i(conv_data), .conv_start_o(conv_start),
      .sel_o(sel), .alert_flags_o(flags));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // Expects the pointer to already hold s
   task automatic do_read(input int s);
      logic [WORD_W-1:0] exp;
      ext_rd = $random(seed);
      if (s == 2)
         ext_rd[15:8] = 8'h00;
      case (s)
         0: exp = {(cfg[3] && (m_over || m_under)), 3'h0, m_res[11:0]};
         1: exp = {14'h0000, m_over[0], m_under[0]};
         default: exp = ext_rd;
      endcase
      u_host.read_reg();
      chk(rd_valid, 1'b1);
      chk(sel, s[2:0]);
      chk(rd_data, exp);
      chk(rd_wide, (s != 1 && s != 2));
      chk(conv_start, (s == 0 && cfg[7:5] == 3'h0));
   endtask : do_read

   task automatic do_write(input int s, input logic [WORD_W-1:0] v, input int gap);
      u_host.write_reg(s[2:0], v, gap);
      chk(sel, s[2:0]);
      chk(ext_wr, (s >= 2));
      if (s >= 2)
         chk(ext_wr_data, {s[2:0], (s == 2) ? {8'h00, v[7:0]} : v});
      if (s == 1) begin
         if (v[1])
            m_over = 0;
         if (v[0])
            m_under = 0;
         chk(flags, {m_over[0], m_under[0]});
      end
   endtask : do_write

   task automatic convert(input int dv);
      @(negedge ref_clk_i);
      conv_done = 1'b1;
      conv_data = dv[11:0];
      @(negedge ref_clk_i);
      conv_done = 1'b0;
      conv_data = ~conv_data;
      m_res = dv;
      if (dv > limits.high)
         m_over = 1;
      else if (!cfg[4] && dv + limits.hysteresis_amount < limits.high)
         m_over = 0;
      if (dv < limits.low)
         m_under = 1;
      else if (!cfg[4] && dv > limits.low + limits.hysteresis_amount)
         m_under = 0;
      chk(flags, {m_over[0], m_under[0]});
   endtask : convert

   initial begin
      cfg = 8'h00;
      limits = '0;
      conv_done = 1'b0;
      conv_data = 12'h000;
      ext_rd = 16'h0000;
      m_over = 0;
      m_under = 0;
      m_res = 0;
      repeat (8) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      chk(sel, 3'h0);
      chk(flags, 2'h0);
      do_read(0);
      $display("test reset done");
      for (int i = 0; i < 120; i++) begin
         cfg = $random(seed) & 8'hFD;
         if (i % 3 == 0)
            cfg[7:5] = 3'h0;
         limits.low = $random(seed);
         limits.high = $random(seed);
         limits.hysteresis_amount = $random(seed) & 12'h0FF;
         h = limits.high;
         l = limits.low;
         y = limits.hysteresis_amount;
         pick = '{$random(seed), h, h + 1, l, l - 1, h - y, h - y - 1, l + y + 1};
         d = pick[{$random(seed)} % 8] & 32'h0000_0FFF;
         convert(d);
         do_write(i % 8, $random(seed), i % 3);
         do_read(i % 8);
         do_write(0, $random(seed), 0);
         do_read(0);
      end
      $display("test random done");
      final_report();
   end

   initial begin
      #100000;
      err_total++;
      final_report();
   end
endmodule : testbench
